//--- core/isdm_pkg.sv
`default_nettype none
package isdm_pkg;

	localparam int CLK_PERIOD_NS = 50;
	// base scl half period; rate select shifts it up to eight times longer
	localparam int SCL_HALF_BASE_NS = 500;
	localparam logic [15:0] SCL_HALF_BASE_CYC =
		16'((SCL_HALF_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] WORD_BITS_FULL = 4'h8;
	localparam logic [1:0] SOFT_RESET_CODE_ARM = 2'h2;
	localparam logic [1:0] SOFT_RESET_CODE_FIRE = 2'h1;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_START = 7'h02,
		ST_LOW = 7'h04,
		ST_HIGH = 7'h08,
		ST_WAIT = 7'h10,
		ST_STOP_LO = 7'h20,
		ST_STOP_HI = 7'h40
	} isdm_state_t;

	typedef struct packed {
		isdm_state_t st;
		logic [15:0] cnt;
		logic [3:0] bits;
		logic [7:0] sh;
		logic [7:0] rxsh;
		logic [3:0] rxcnt;
		logic first;
		logic engaged;
		logic maddr;
		logic dir;
		logic scl_p;
		logic sda_p;
		logic scl_oe;
		logic sda_oe;
		logic scl_o;
		logic sda_o;
		logic master_select;
		logic transmit_select;
		logic bb;
		logic pin_n;
		logic addressed_as_slave_flag;
		logic gc;
		logic irq;
		logic swarm;
	} isdm_core_t;

	localparam isdm_core_t CORE_RESET = '{
		st: ST_IDLE, cnt: 16'h0000, bits: 4'h0, sh: 8'h00, rxsh: 8'h00, rxcnt: 4'h0,
		first: 1'b0, engaged: 1'b0, maddr: 1'b0, dir: 1'b0, scl_p: 1'b1, sda_p: 1'b1,
		scl_oe: 1'b0, sda_oe: 1'b0, scl_o: 1'b0, sda_o: 1'b0, master_select: 1'b0, transmit_select: 1'b0,
		bb: 1'b0, pin_n: 1'b1, addressed_as_slave_flag: 1'b0, gc: 1'b0, irq: 1'b0, swarm: 1'b0};

	typedef struct packed {
		logic lb;
	} isdm_link_t;

	localparam isdm_link_t LINK_RESET = '{lb: 1'b1};

endpackage
`default_nettype wire

//--- core/isdm_sync.sv
`default_nettype none
module isdm_sync import isdm_pkg::*; #(
	parameter int WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} isdm_sync_t;

	isdm_sync_t q;
	isdm_sync_t d;

	// idle bus level is high, so reset to ones avoids a false edge
	always_comb begin
		d.meta = i_async;
		d.stable = q.meta;
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '1;
		end else begin
			q <= d;
		end
	end

	assign o_sync = q.stable;

endmodule
`default_nettype wire

//--- core/isdm_core.sv
`default_nettype none
module isdm_core import isdm_pkg::*; (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_scl_link_clk,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_scl_o,
	output logic o_scl_oe,
	output logic o_sda_o,
	output logic o_sda_oe,
	input wire logic i_block_power_enable,
	input wire logic i_interface_enable,
	input wire logic i_handshake_clock_enable,
	input wire logic i_address_detect_disable,
	input wire logic i_free_format_select,
	input wire logic [2:0] i_bit_count_select,
	input wire logic [1:0] i_clock_rate_select,
	input wire logic [6:0] i_own_slave_address,
	input wire logic i_ctl_wr,
	input wire logic i_wr_master_select,
	input wire logic i_wr_transmit_select,
	input wire logic i_wr_bus_busy_flag,
	input wire logic i_wr_transfer_pending_n,
	input wire logic [1:0] i_soft_reset_code,
	input wire logic i_sdb_wr,
	input wire logic [7:0] i_sdb_wdata,
	input wire logic i_sdb_rd,
	output logic [7:0] o_sdb_rdata,
	output logic o_master_select,
	output logic o_transmit_select,
	output logic o_bus_busy_flag,
	output logic o_transfer_pending_n,
	output logic o_addressed_as_slave_flag,
	output logic o_general_call_flag,
	output logic o_last_bit_captured,
	output logic o_transfer_interrupt
);

	////////////////////////////////////////////////////////////////////////////////
	// link domain: sda captured on scl rising edges

	isdm_link_t lq;
	isdm_link_t ld;

	always_comb begin
		ld.lb = i_sda;
	end

	// scl only toggles during frames; the captured bit simply holds in between
	always_ff @(posedge i_scl_link_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lq <= LINK_RESET;
		end else begin
			lq <= ld;
		end
	end

	isdm_sync #(.WIDTH(1)) u_lb_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async(lq.lb),
		.o_sync(o_last_bit_captured)
	);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [1:0] pins_s;
	logic scl_s;
	logic sda_s;

	isdm_sync #(.WIDTH(2)) u_pin_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async({i_scl, i_sda}),
		.o_sync(pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	////////////////////////////////////////////////////////////////////////////////
	// bus events and word sizing

	isdm_core_t q;
	isdm_core_t n;

	logic en;
	logic start_det;
	logic stop_det;
	logic scl_rise;
	logic scl_fall;
	logic [3:0] word_bits;
	logic [3:0] total_bits;
	logic [15:0] half_cyc;
	logic [7:0] rx_byte;
	logic first_done;
	logic cmd_start;
	logic cmd_stop;
	logic soft_rst;

	assign en = i_block_power_enable & i_interface_enable;
	assign start_det = scl_s & q.scl_p & q.sda_p & ~sda_s;
	assign stop_det = scl_s & q.scl_p & ~q.sda_p & sda_s;
	assign scl_rise = scl_s & ~q.scl_p;
	assign scl_fall = ~scl_s & q.scl_p;
	assign word_bits = (i_bit_count_select == 3'h0) ? WORD_BITS_FULL
		: {1'b0, i_bit_count_select};
	assign total_bits = word_bits + {3'h0, i_handshake_clock_enable};
	assign half_cyc = SCL_HALF_BASE_CYC << i_clock_rate_select;
	assign rx_byte = {q.rxsh[6:0], sda_s};
	assign first_done = en & ~q.master_select & scl_rise & q.first & (q.rxcnt == word_bits - 4'h1);
	assign cmd_start = en & i_ctl_wr & i_wr_master_select & i_wr_transmit_select
		& i_wr_bus_busy_flag & i_wr_transfer_pending_n & ~q.bb & (q.st == ST_IDLE);
	assign cmd_stop = en & i_ctl_wr & i_wr_master_select & i_wr_transmit_select
		& ~i_wr_bus_busy_flag & i_wr_transfer_pending_n & q.bb & q.master_select;
	assign soft_rst = en & i_ctl_wr & q.swarm & (i_soft_reset_code == SOFT_RESET_CODE_FIRE);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		n = q;
		n.irq = 1'b0;
		n.scl_p = scl_s;
		n.sda_p = sda_s;

		// software side first, so hardware sets below win a same-cycle clear
		if (i_sdb_wr) begin
			n.sh = i_sdb_wdata;
			n.pin_n = 1'b1;
			n.addressed_as_slave_flag = 1'b0;
		end
		if (i_sdb_rd) begin
			n.addressed_as_slave_flag = 1'b0;
		end
		if (en && i_ctl_wr) begin
			n.swarm = (i_soft_reset_code == SOFT_RESET_CODE_ARM);
			if (i_wr_transfer_pending_n) begin
				n.pin_n = 1'b1;
			end
			if (cmd_start) begin
				n.master_select = 1'b1;
				n.transmit_select = 1'b1;
				n.st = ST_START;
				n.sda_oe = 1'b1;
				n.cnt = 16'h0000;
				n.bits = 4'h0;
				n.maddr = 1'b1;
				n.dir = q.sh[0];
			end else if (cmd_stop) begin
				n.st = ST_STOP_LO;
				n.cnt = 16'h0000;
			end else begin
				n.master_select = i_wr_master_select;
				n.transmit_select = i_wr_transmit_select;
			end
		end

		// bus monitor
		if (start_det) begin
			n.bb = 1'b1;
			n.gc = 1'b0;
			n.first = 1'b1;
			n.rxcnt = 4'h0;
			n.engaged = 1'b0;
		end
		if (stop_det) begin
			n.bb = 1'b0;
			n.gc = 1'b0;
			n.first = 1'b0;
			n.engaged = 1'b0;
			n.master_select = 1'b0;
			n.transmit_select = 1'b0;
		end

		// slave receive path
		if (en && !q.master_select && !start_det && !stop_det) begin
			if (scl_rise) begin
				n.rxsh = (q.rxcnt < word_bits) ? rx_byte : q.rxsh; // ack clock kept out of the word
				n.rxcnt = q.rxcnt + 4'h1;
			end
			if (first_done) begin
				n.first = 1'b0;
				if (i_free_format_select) begin
					n.addressed_as_slave_flag = 1'b1;
					n.engaged = 1'b1;
				end else if (!i_address_detect_disable) begin
					if (rx_byte == 8'h00) begin
						n.gc = 1'b1;
						n.addressed_as_slave_flag = 1'b1;
						n.engaged = 1'b1;
					end else if (rx_byte[7:1] == i_own_slave_address) begin
						n.addressed_as_slave_flag = 1'b1;
						n.engaged = 1'b1;
						n.transmit_select = rx_byte[0];
					end
				end
			end
			if (scl_fall && q.rxcnt == word_bits && q.engaged && i_handshake_clock_enable) begin
				n.sda_oe = 1'b1;
			end
			if (scl_fall && q.rxcnt == total_bits) begin
				n.sda_oe = 1'b0;
				n.rxcnt = 4'h0;
				if (q.engaged) begin
					n.irq = 1'b1;
					n.pin_n = 1'b0;
				end
			end
			n.scl_oe = ~n.pin_n;
		end

		// master transmitter engine
		unique case (q.st)
			ST_IDLE: begin
			end
			ST_START: begin
				n.cnt = q.cnt + 16'h0001;
				if (q.cnt == half_cyc - 16'h0001) begin
					n.scl_oe = 1'b1;
					n.st = ST_LOW;
					n.cnt = 16'h0000;
				end
			end
			ST_LOW: begin
				n.cnt = q.cnt + 16'h0001;
				if (q.cnt == 16'h0000) begin
					// acknowledge slot: transmitter lets go of sda
					n.sda_oe = (q.bits < word_bits) ? ~q.sh[7] : 1'b0;
				end
				if (q.cnt == half_cyc - 16'h0001) begin
					n.scl_oe = 1'b0;
					n.st = ST_HIGH;
					n.cnt = 16'h0000;
				end
			end
			ST_HIGH: begin
				// count only once scl is really high, so a stretching slave is honoured
				if (scl_s) begin
					n.cnt = q.cnt + 16'h0001;
					if (q.cnt == half_cyc - 16'h0001) begin
						n.scl_oe = 1'b1;
						n.cnt = 16'h0000;
						n.bits = q.bits + 4'h1;
						if (q.bits < word_bits) begin
							n.sh = {q.sh[6:0], 1'b0};
						end
						if (q.bits + 4'h1 == total_bits) begin
							n.irq = 1'b1;
							n.pin_n = 1'b0;
							n.st = ST_WAIT;
							n.maddr = 1'b0;
							if (q.maddr && i_handshake_clock_enable && !sda_s) begin
								n.transmit_select = ~q.dir;
							end
						end else begin
							n.st = ST_LOW;
						end
					end
				end
			end
			ST_WAIT: begin
				n.scl_oe = 1'b1;
				if (q.pin_n) begin
					n.st = ST_LOW;
					n.cnt = 16'h0000;
					n.bits = 4'h0;
				end
			end
			ST_STOP_LO: begin
				n.scl_oe = 1'b1;
				n.sda_oe = 1'b1;
				n.cnt = q.cnt + 16'h0001;
				if (q.cnt == half_cyc - 16'h0001) begin
					n.scl_oe = 1'b0;
					n.st = ST_STOP_HI;
					n.cnt = 16'h0000;
				end
			end
			ST_STOP_HI: begin
				if (scl_s) begin
					n.cnt = q.cnt + 16'h0001;
					if (q.cnt == half_cyc - 16'h0001) begin
						n.sda_oe = 1'b0;
						n.st = ST_IDLE;
					end
				end
			end
		endcase

		// a soft reset or a disabled block must not keep the lines low
		if (soft_rst || !en) begin
			n.st = ST_IDLE;
			n.master_select = 1'b0;
			n.transmit_select = 1'b0;
			n.pin_n = 1'b1;
			n.scl_oe = 1'b0;
			n.sda_oe = 1'b0;
			n.engaged = 1'b0;
			n.rxcnt = 4'h0;
			n.swarm = 1'b0;
			n.irq = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= CORE_RESET;
		end else begin
			q <= n;
		end
	end

	assign o_scl_o = q.scl_o;
	assign o_scl_oe = q.scl_oe;
	assign o_sda_o = q.sda_o;
	assign o_sda_oe = q.sda_oe;
	assign o_sdb_rdata = q.rxsh;
	assign o_master_select = q.master_select;
	assign o_transmit_select = q.transmit_select;
	assign o_bus_busy_flag = q.bb;
	assign o_transfer_pending_n = q.pin_n;
	assign o_addressed_as_slave_flag = q.addressed_as_slave_flag;
	assign o_general_call_flag = q.gc;
	assign o_transfer_interrupt = q.irq;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	property p_addr_match;
		@(posedge i_clk) disable iff (!i_reset_n)
		(first_done && !i_free_format_select && !i_address_detect_disable
			&& !start_det && !stop_det && rx_byte[7:1] == i_own_slave_address) |=> q.addressed_as_slave_flag;
	endproperty
	a_addr_match: assert property (p_addr_match) else $error("own address not flagged");

	property p_nack_quiet;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_address_detect_disable && !i_free_format_select && !q.gc && !q.addressed_as_slave_flag)
			|=> (!q.gc && !q.addressed_as_slave_flag);
	endproperty
	a_nack_quiet: assert property (p_nack_quiet) else $error("detection while disabled");

	property p_free_format;
		@(posedge i_clk) disable iff (!i_reset_n)
		(first_done && i_free_format_select && !start_det && !stop_det) |=> q.addressed_as_slave_flag;
	endproperty
	a_free_format: assert property (p_free_format) else $error("free format word not flagged");

	property p_aas_clear;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_sdb_rd && !first_done) |=> !q.addressed_as_slave_flag;
	endproperty
	a_aas_clear: assert property (p_aas_clear) else $error("buffer read kept addressed flag");

	property p_gcall;
		@(posedge i_clk) disable iff (!i_reset_n)
		(first_done && !i_free_format_select && !i_address_detect_disable
			&& !start_det && !stop_det && rx_byte == 8'h00) |=> (q.gc && q.addressed_as_slave_flag);
	endproperty
	a_gcall: assert property (p_gcall) else $error("general call missed");

	property p_gc_clear;
		@(posedge i_clk) disable iff (!i_reset_n)
		(start_det || stop_det) |=> !q.gc;
	endproperty
	a_gc_clear: assert property (p_gc_clear) else $error("general call survived bus condition");

	property p_start_hold;
		@(posedge i_clk) disable iff (!i_reset_n)
		(cmd_start && !soft_rst) |=> (q.sda_oe && !q.scl_oe) [*2];
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("scl fell too early after start");

	property p_irq_pending;
		@(posedge i_clk) disable iff (!i_reset_n)
		q.irq |-> (!q.pin_n && q.scl_oe);
	endproperty
	a_irq_pending: assert property (p_irq_pending) else $error("interrupt without pending clear");

	property p_stretch;
		@(posedge i_clk) disable iff (!i_reset_n)
		!q.pin_n |-> q.scl_oe;
	endproperty
	a_stretch: assert property (p_stretch) else $error("scl released while pending low");

	property p_pending_sticky;
		@(posedge i_clk) disable iff (!i_reset_n)
		(!q.pin_n && i_ctl_wr && !i_wr_transfer_pending_n && !i_sdb_wr && !soft_rst && en)
			|=> !q.pin_n;
	endproperty
	a_pending_sticky: assert property (p_pending_sticky) else $error("software cleared pending");

	property p_busy;
		@(posedge i_clk) disable iff (!i_reset_n)
		(start_det |=> q.bb) and (stop_det |=> !q.bb);
	endproperty
	a_busy: assert property (p_busy) else $error("bus busy flag wrong");

endmodule
`default_nettype wire

//--- verification/isdm_bus_model.sv
`default_nettype none
module isdm_bus_model (
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_ack_addr,
	input wire logic i_ack_data,
	output logic o_scl_oe,
	output logic o_sda_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rx_q[$];
	logic [7:0] sh = 8'h00;
	logic active = 1'b0;
	int cnt = 0;
	initial begin
		o_scl_oe = 1'b0;
		o_sda_oe = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// master side: 160 ns bus clock that runs only inside a frame
	task automatic w_high();
		int n;
		n = 0;
		#1;
		while (i_scl !== 1'b1 && n < 400000) begin // a stretched clock is waited out
			#1;
			n++;
		end
	endtask
	task automatic m_start();
		#13 o_sda_oe = 1'b1; // sda falls while scl is high
		#200 o_scl_oe = 1'b1;
		#80;
	endtask
	task automatic m_bit(input logic b, output logic s);
		#40 o_sda_oe = ~b;
		#40 o_scl_oe = 1'b0;
		w_high();
		s = i_sda;
		#79 o_scl_oe = 1'b1;
	endtask
	task automatic m_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) m_bit(b[i], s);
		// long low phase: the slave sees the fall two clock flops late before it acknowledges
		#400;
		m_bit(1'b1, ack); // ninth clock with sda released
	endtask
	task automatic m_stop();
		#40 o_sda_oe = 1'b1;
		#40 o_scl_oe = 1'b0;
		w_high();
		#80 o_sda_oe = 1'b0; // sda rises while scl is high
		#200;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// slave side: only frames started by someone else are answered
	always @(negedge i_sda) if (i_scl === 1'b1 && o_sda_oe !== 1'b1) begin
		active = 1'b1;
		cnt = 0;
	end
	always @(posedge i_sda) if (i_scl === 1'b1) active = 1'b0;
	always @(posedge i_scl) if (active && cnt < 8) begin
		sh = {sh[6:0], i_sda};
		cnt++;
	end
	always @(negedge i_scl) if (active) begin
		if (cnt == 8) begin
			rx_q.push_back(sh);
			o_sda_oe = (rx_q.size() == 1) ? i_ack_addr : i_ack_data;
			cnt = 9;
		end else if (cnt == 9) begin
			o_sda_oe = 1'b0; // hold ends at the ninth fall, pull-up takes over
			cnt = 0;
		end
	end
endmodule
`default_nettype wire

//--- verification/isdm_core_bench.sv
`default_nettype none
module isdm_core_bench import isdm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, pwr, ien, hs, nodet, ffs, ctl_wr, w_mst, w_trx, w_bb, w_pin;
	logic sdb_wr, sdb_rd, ack_a, ack_d, scl_w, sda_w;
	logic [2:0] bcs;
	logic [1:0] rate, soft_reset_code;
	logic [6:0] own;
	logic [7:0] sdb_wd, rdata;
	logic master_select, transmit_select, bb, pin_n, addressed_as_slave_flag, gc, last_bit_captured, irq, scl_oe, sda_oe, m_scl_oe, m_sda_oe;
	int n_mismatch = 0;
	int samples_checked = 0;
	int n_irq = 0;
	// {byte, detect off, free format, addressed, general call}
	logic [11:0] tbl [6] = '{12'h5a2, 12'h003, 12'h5a8, 12'h008, 12'h3c0, 12'h3c6};
	assign scl_w = ~(scl_oe | m_scl_oe);
	assign sda_w = ~(sda_oe | m_sda_oe);
	isdm_core i_isdm_core (.i_clk(clk), .i_reset_n(rst_n), .i_scl_link_clk(scl_w),
		.i_scl(scl_w), .i_sda(sda_w), .o_scl_o(), .o_scl_oe(scl_oe), .o_sda_o(),
		.o_sda_oe(sda_oe), .i_block_power_enable(pwr), .i_interface_enable(ien),
		.i_handshake_clock_enable(hs), .i_address_detect_disable(nodet),
		.i_free_format_select(ffs), .i_bit_count_select(bcs), .i_clock_rate_select(rate),
		.i_own_slave_address(own), .i_ctl_wr(ctl_wr), .i_wr_master_select(w_mst),
		.i_wr_transmit_select(w_trx), .i_wr_bus_busy_flag(w_bb),
		.i_wr_transfer_pending_n(w_pin), .i_soft_reset_code(soft_reset_code), .i_sdb_wr(sdb_wr),
		.i_sdb_wdata(sdb_wd), .i_sdb_rd(sdb_rd), .o_sdb_rdata(rdata),
		.o_master_select(master_select), .o_transmit_select(transmit_select), .o_bus_busy_flag(bb),
		.o_transfer_pending_n(pin_n), .o_addressed_as_slave_flag(addressed_as_slave_flag),
		.o_general_call_flag(gc), .o_last_bit_captured(last_bit_captured), .o_transfer_interrupt(irq));
	isdm_bus_model i_isdm_bus_model (.i_scl(scl_w), .i_sda(sda_w), .i_ack_addr(ack_a),
		.i_ack_data(ack_d), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// the interrupt is a one-cycle pulse, so it is counted rather than polled
	always @(posedge clk) if (irq === 1'b1) n_irq++;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_bit(input string what, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %b seen %b", what, e, g);
		end
	endtask
	task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic ctl(input logic [3:0] v);
		{w_mst, w_trx, w_bb, w_pin, ctl_wr} = {v, 1'b1};
		@(negedge clk);
		ctl_wr = 1'b0;
		cyc(2);
	endtask
	task automatic sdb(input logic rd, input logic [7:0] d);
		{sdb_rd, sdb_wr, sdb_wd} = {rd, ~rd, d};
		@(negedge clk);
		{sdb_rd, sdb_wr} = 2'b00;
		cyc(2);
	endtask
	task automatic wait_irq();
		int k;
		k = n_irq;
		repeat (4000) if (n_irq == k) @(negedge clk);
		chk_bit("interrupt", 1'b1, n_irq == k + 1);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic scase(input logic [7:0] b, input logic nd, input logic ff, input logic ea,
		input logic eg);
		logic ak;
		{nodet, ffs} = {nd, ff};
		cyc(1);
		i_isdm_bus_model.m_start();
		i_isdm_bus_model.m_byte(b, ak);
		cyc(6);
		chk_bit("addressed", ea, addressed_as_slave_flag);
		chk_bit("general call", eg, gc);
		chk_bit("busy", 1'b1, bb);
		chk_bit("last bit", ak, last_bit_captured);
		chk_bit("slave ack", ~ea, ak);
		chk_byte("received byte", b, rdata);
		if (ea) begin
			chk_bit("scl held", 1'b1, scl_oe);
			ctl(4'h0);
			chk_bit("pending kept", 1'b0, pin_n);
			sdb(1'b1, 8'h00);
			chk_bit("addressed cleared", 1'b0, addressed_as_slave_flag);
			sdb(1'b0, 8'h00);
			chk_bit("released", 1'b1, pin_n);
		end
		i_isdm_bus_model.m_stop();
		cyc(6);
		chk_bit("general call cleared", 1'b0, gc);
		chk_bit("busy cleared", 1'b0, bb);
	endtask
	task automatic mtx(input logic [7:0] a, input logic ack, input logic exp_trx);
		int h;
		ack_a = ack;
		i_isdm_bus_model.rx_q.delete();
		sdb(1'b0, a); // buffer loaded while idle, start follows at once
		{w_mst, w_trx, w_bb, w_pin, ctl_wr} = 5'h1f;
		@(negedge clk);
		ctl_wr = 1'b0;
		h = 0;
		repeat (200) begin
			if (sda_oe === 1'b1 && scl_oe !== 1'b1) h++;
			if (scl_oe !== 1'b1) @(negedge clk);
		end
		chk_byte("start hold", 8'(SCL_HALF_BASE_CYC), 8'(h));
		wait_irq();
		cyc(1);
		chk_bit("pending", 1'b0, pin_n);
		chk_bit("scl held", 1'b1, scl_oe);
		chk_bit("busy", 1'b1, bb);
		chk_bit("master", 1'b1, master_select);
		chk_bit("direction", exp_trx, transmit_select);
		chk_bit("address ack", ~ack, last_bit_captured);
		chk_byte("address out", a, i_isdm_bus_model.rx_q[0]);
		if (ack && !a[0]) begin
			sdb(1'b0, 8'hc3);
			chk_bit("pending set", 1'b1, pin_n);
			wait_irq();
			cyc(1);
			chk_byte("data out", 8'hc3, i_isdm_bus_model.rx_q[1]);
			chk_bit("data nack", 1'b1, last_bit_captured);
		end
		ctl(4'hd); // stop on nack or when done
		repeat (400) if (bb !== 1'b0) @(negedge clk);
		chk_bit("busy after stop", 1'b0, bb);
		chk_bit("master after stop", 1'b0, master_select);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, pwr, ien, hs, nodet, ffs, ctl_wr, w_mst, w_trx, w_bb, w_pin} = 11'h000;
		{sdb_wr, sdb_rd, ack_a, ack_d} = 4'h0;
		{bcs, rate, soft_reset_code, own, sdb_wd} = {3'h0, 2'h0, 2'h0, 7'h2d, 8'h00};
		cyc(10);
		rst_n = 1'b1;
		cyc(3);
		chk_bit("pending at reset", 1'b1, pin_n);
		chk_bit("last bit at reset", 1'b1, last_bit_captured);
		pwr = 1'b1;
		cyc(1);
		chk_bit("bus idle", 1'b1, scl_w & sda_w);
		{ien, hs} = 2'b11;
		cyc(1);
		ctl(4'h1); // slave receiver defaults
		foreach (tbl[i]) scase(tbl[i][11:4], tbl[i][3], tbl[i][2], tbl[i][1], tbl[i][0]);
		{nodet, ffs} = 2'b00;
		mtx(8'ha3, 1'b0, 1'b1);
		mtx(8'ha3, 1'b1, 1'b0);
		mtx(8'ha2, 1'b1, 1'b1);
		wrap_up();
	end
	initial begin
		#2000000;
		n_mismatch++;
		wrap_up();
	end
endmodule
`default_nettype wire
